// ---- dv/tch_ctrl_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// ************
// Port checks
// ************
module tch_ctrl_monitor
    import tch_pkg::*;
(
    // Watched ports
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [3:0] adc_channel,
    input wire logic adc_mode8,
    input wire logic adc_step,
    input wire logic adc_sample,
    input wire logic adc_on,
    input wire logic x_drv_on,
    input wire logic y_low_gnd,
    input wire logic pen_connect,
    input wire logic [SMP_W-1:0] result,
    input wire logic result_valid
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    od_low_a: assert property (!scl_out && !sda_out)
        else $error("bus data not low");
    sda_still_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda moved with scl high");
    fast_step_a: assert property (adc_step && adc_mode8 |=> (!adc_step)[*5])
        else $error("fast step too soon");
    slow_step_a: assert property (adc_step && !adc_mode8 |=>
        (!adc_step)[*8] ##1 (!adc_step)[*3])
        else $error("slow step too soon");
    meas_pen_a: assert property (adc_sample |-> !pen_connect && adc_on && !result_valid)
        else $error("sample with pen path");
    pen_gnd_a: assert property (pen_connect |-> y_low_gnd)
        else $error("pen path without ground");
    drv_pen_a: assert property (x_drv_on && adc_channel == FN_DRV_X |-> !pen_connect)
        else $error("driver command kept pen");
    res_hold_a: assert property (result_valid && $past(result_valid) |-> $stable(result))
        else $error("result moved while valid");
endmodule // tch_ctrl_monitor
bind tch_ctrl tch_ctrl_monitor i_tch_ctrl_monitor (.*);
`default_nettype wire

// ---- dv/tch_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tch_ctrl_tb;
    import tch_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic address_select_pin = 1'b0;
    logic x_high_level = 1'b1;
    logic [SMP_W-1:0] adc_code = 12'hAB0;
    logic scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, adc_on, adc_mode8, adc_step;
    logic adc_sample, x_drv_on, y_drv_on, yx_drv_on, y_low_gnd, pen_connect, pen_touch_irq_n;
    logic irq_pull_90k, filter_bypass, result_valid;
    logic [3:0] adc_channel;
    logic [SMP_W-1:0] result;
    logic [11:0] tbl [7] = '{12'hAB0, 12'h101, 12'h301, 12'h201, 12'h900, 12'h050, 12'h060};
    logic [12:0] rows [5] = '{{8'hB1, 5'h03}, {8'hB0, 5'h02}, {8'h80, 5'h10}, {8'h90, 5'h08},
        {8'hA0, 5'h04}};
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int si = 0;
    int nstep = 0;
    int nsmp = 0;
    always #20 mclk = ~mclk;
    tch_ctrl i_tch_ctrl (.*);
    tch_host i_tch_host (.*);
    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] c, output logic k1, output logic k2);
        i_tch_host.start();
        i_tch_host.wb(a, k1);
        i_tch_host.wb(c, k2);
        i_tch_host.stop();
    endtask
    task automatic clr();
        @(posedge mclk);
        adc_code <= tbl[0];
        si = 0;
        nstep = 0;
        nsmp = 0;
    endtask
    task automatic wait_rv();
        while (result_valid !== 1'b1)
            @(posedge mclk);
        #1;
    endtask
    // Timeout, step count and converter feed
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (adc_step)
            nstep++;
        if (adc_sample)
        begin
            nsmp++;
            si = (si + 1) % 7;
            adc_code <= tbl[si];
        end
        if (cyc == 50000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    initial
    begin
        logic a1, a2;
        logic [7:0] d;
        repeat (10) @(posedge mclk);
        #1;
        chk("reset", {sda_oe, scl_oe, pen_touch_irq_n, pen_connect, y_low_gnd, adc_on,
            result_valid, irq_pull_90k, result}, 20'h3_8000);
        sys_rst <= 1'b0;
        repeat (5) @(posedge mclk);
        foreach (rows[i])
        begin
            wr(8'h90, rows[i][12:5], a1, a2);
            repeat (20) @(posedge mclk);
            #1;
            chk("ack", {a1, a2}, 2'h3);
            chk("drv", {x_drv_on, y_drv_on, yx_drv_on, pen_touch_irq_n,
                irq_pull_90k}, rows[i][4:0]);
        end
        i_tch_host.start();
        i_tch_host.wb(8'h92, a1);
        i_tch_host.stop();
        i_tch_host.start();
        i_tch_host.wb(8'h08, a2);
        i_tch_host.stop();
        chk("nack", {a1, a2}, 2'h0);
        address_select_pin <= 1'b1;
        wr(8'h92, 8'hB0, a1, a2);
        chk("pin", {a1, a2}, 2'h3);
        address_select_pin <= 1'b0;
        clr();
        wr(8'h90, 8'hC0, a1, a2);
        wait_rv();
        chk("steps", nstep, 112);
        chk("samples", nsmp, 7);
        chk("result", result, 12'h201);
        // Touch applied only outside writes
        x_high_level <= 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        chk("pen", {pen_connect, pen_touch_irq_n, x_drv_on}, 3'h4);
        x_high_level <= 1'b1;
        i_tch_host.start();
        i_tch_host.wb(8'h91, a1);
        i_tch_host.rb(1'b1, d);
        chk("hi", {a1, d}, 9'h120);
        i_tch_host.rb(1'b0, d);
        chk("lo", d, 8'h10);
        #1;
        chk("rel", sda_oe, 1'b0);
        i_tch_host.stop();
        wr(8'h90, 8'hB2, a1, a2);
        clr();
        i_tch_host.start();
        i_tch_host.wb(8'h90, a1);
        i_tch_host.wb(8'hC6, a2);
        i_tch_host.start();
        i_tch_host.wb(8'h90, a1);
        i_tch_host.stop();
        wait_rv();
        chk("steps8", nstep, 12);
        chk("samples8", nsmp, 1);
        chk("hold", {adc_on, adc_mode8, pen_connect, filter_bypass}, 4'hD);
        i_tch_host.start();
        i_tch_host.wb(8'h91, a1);
        i_tch_host.rb(1'b0, d);
        i_tch_host.stop();
        chk("byte8", d, 8'hAB);
        // High-speed read arrives before the filtered result
        i_tch_host.start();
        i_tch_host.wb(8'h08, a1);
        i_tch_host.start();
        i_tch_host.wb(8'h90, a1);
        i_tch_host.wb(8'hB0, a2);
        i_tch_host.wb(8'hC2, a2);
        i_tch_host.start();
        i_tch_host.wb(8'h91, a1);
        i_tch_host.rb(1'b0, d);
        i_tch_host.stop();
        chk("hs", {a1, a2, d}, 10'h320);
        end_sim();
    end
endmodule // tch_ctrl_tb
`default_nettype wire

// ---- dv/tch_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module tch_host
(
    // Bus
    input wire logic mclk,
    input wire logic scl_oe,
    input wire logic sda_oe,
    output logic scl_in,
    output logic sda_in
);
    logic scl_m = 1'b1;
    logic sda_m = 1'b1;
    // Pull-ups on both lines
    assign scl_in = scl_m && !scl_oe;
    assign sda_in = sda_m && !sda_oe;
    task automatic q();
        repeat (10) @(posedge mclk);
    endtask
    task automatic bx(input logic b, output logic s);
        sda_m <= b;
        q();
        scl_m <= 1'b1;
        q();
        // Slave may stretch the low phase
        while (!scl_in)
            @(posedge mclk);
        s = sda_in;
        q();
        scl_m <= 1'b0;
        q();
    endtask
    task automatic start();
        sda_m <= 1'b1;
        q();
        scl_m <= 1'b1;
        q();
        sda_m <= 1'b0;
        q();
        scl_m <= 1'b0;
        q();
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        q();
        scl_m <= 1'b1;
        q();
        sda_m <= 1'b1;
        q();
    endtask
    task automatic wb(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bx(d[i], s);
        bx(1'b1, s);
        ack = !s;
    endtask
    task automatic rb(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bx(1'b1, d[i]);
        bx(!mack, s);
    endtask
endmodule // tch_host
`default_nettype wire

// ---- hw/tch_ctrl.sv ----
// Function
// - Driver-only command turns selected panel drivers on without converting.
// - Mode bit high gives 8-bit result in one byte; low gives 12-bit.
// - Converter clock enable is mclk/6 (about 4.17 MHz) in 8-bit mode, mclk/12 (about 2.08 MHz) in 12-bit.
// - 8-bit conversion uses four fewer bit steps on the faster clock.
// - Results are unsigned straight binary codes.
// - Setup command low nibble picks pen pull-up: last bit 1 means 90k.
// - Power-down with hold bit 0 grounds Y low and routes X high to irq.
// - Measurements disconnect X high from the pen-detect path.
// - Driver-only commands disable pen detect and force irq low.
// - Hold bit 1 keeps pen detect off until a measurement with hold 0 completes.
// - Write address ack disables pen; hold 0 measurement re-enables at end.
// - Filter sorts seven samples and averages the middle three.
// - Filter serves every input; setup command can bypass it.
// - Device is a bus slave only, open-drain, at all bus rates.
// - START is SDA fall with SCL high; STOP is SDA rise.
// - Transfers run START to STOP; every byte gets a ninth ack bit.
// - Ack holds SDA low through the ninth clock high phase.
// - On master not-ack the slave releases SDA for STOP.
// - Write transfer acks matching address and every data byte.
// - Repeated START begins a new transfer.
// - Address matched in hardware; read selects transmit, write receive.
// - Address is 100100 plus address pin; eighth bit is direction.
// - Power bits: hold 0 pen enabled, hold 1 converter on, pen off.
// - Master code 00001xxx is never acked; it enters high speed.
// - In high speed, SCL low is stretched until data are loaded.
`timescale 1ns/10ps
`default_nettype none

module tch_ctrl
    import tch_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    // Address strap
    input wire logic address_select_pin,
    // Converter
    input wire logic [SMP_W-1:0] adc_code,
    output logic [3:0] adc_channel,
    output logic adc_on,
    output logic adc_mode8,
    output logic adc_step,
    output logic adc_sample,
    // Panel and pen detect
    input wire logic x_high_level,
    output logic x_drv_on,
    output logic y_drv_on,
    output logic yx_drv_on,
    output logic y_low_gnd,
    output logic pen_connect,
    output logic pen_touch_irq_n,
    output logic irq_pull_90k,
    // Status
    output logic filter_bypass,
    output logic [SMP_W-1:0] result,
    output logic result_valid
);

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] pen_s;
        logic [1:0] a0_s;
        tch_i2c_e i2c;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic is_addr;
        logic rd;
        logic hs;
        logic mack;
        logic bsel;
        logic pend;
        logic [7:0] cmd;
        logic scl_oe;
        logic sda_oe;
        logic sda_o;
        tch_conv_e conv;
        logic [3:0] div;
        logic [4:0] step;
        logic [2:0] smp;
        logic [FILT_N-1:0][SMP_W-1:0] sbuf;
        logic [SMP_W-1:0] result;
        logic res_ready;
        logic byp_run;
        logic filt_byp;
        logic pull90;
        logic hold;
        logic mode8;
        logic drv_only;
        logic measuring;
        logic pen_en;
        logic [3:0] chan;
        logic adc_on;
        logic adc_step;
        logic adc_sample;
        logic x_drv;
        logic y_drv;
        logic yx_drv;
        logic y_low_gnd;
        logic pen_connect;
        logic irq_n;
    } tch_st_s;

    tch_st_s st;
    tch_st_s next_st;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic launch;
    logic [3:0] fn;
    logic [3:0] div_max;
    logic [4:0] steps;
    logic [2:0] nsmp;
    logic [SMP_W-1:0] mav_avg;

    // ****************************************
    // Bus events from synchronised lines
    // ****************************************
    assign scl_rise = st.scl_s[1] & ~st.scl_s[2];
    assign scl_fall = ~st.scl_s[1] & st.scl_s[2];
    assign start_c = st.scl_s[1] & st.scl_s[2] & ~st.sda_s[1] & st.sda_s[2];
    assign stop_c = st.scl_s[1] & st.scl_s[2] & st.sda_s[1] & ~st.sda_s[2];
    // Conversion begins on the bus condition that closes the command
    assign launch = (start_c | stop_c) & st.pend;
    assign fn = st.cmd[7:4];
    assign div_max = st.mode8 ? DIV_FAST : DIV_SLOW;
    assign steps = (st.mode8 ? BITS_WIDE - BIT_TRIM : BITS_WIDE) + OVH_STEPS;
    assign nsmp = st.byp_run ? 3'h0 : FILT_LAST;

    // Byte to send; in 8-bit mode every byte repeats the code
    function automatic logic [7:0] rd_byte(input logic sel);
        rd_byte = (sel & ~st.mode8) ? {st.result[3:0], 4'h0} : st.result[11:4];
    endfunction

    tch_mav #(
        .W(SMP_W),
        .N(FILT_N)
    ) u_mav (
        .smp(st.sbuf),
        .avg(mav_avg)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_st = st;
        next_st.adc_step = 1'b0;
        next_st.adc_sample = 1'b0;
        next_st.sda_o = 1'b0;
        next_st.scl_s = {st.scl_s[1:0], scl_in};
        next_st.sda_s = {st.sda_s[1:0], sda_in};
        next_st.pen_s = {st.pen_s[0], x_high_level};
        next_st.a0_s = {st.a0_s[0], address_select_pin};

        // Bus slave; never drives SCL high, only pulls low
        if (start_c)
        begin
            // Repeated START is handled just like a first one
            next_st.i2c = I_RX;
            next_st.is_addr = 1'b1;
            next_st.bit_cnt = 4'h0;
            next_st.sda_oe = 1'b0;
            next_st.scl_oe = 1'b0;
        end
        else if (stop_c)
        begin
            next_st.i2c = I_IDLE;
            next_st.hs = 1'b0;
            next_st.sda_oe = 1'b0;
            next_st.scl_oe = 1'b0;
        end
        else
        begin
            case (st.i2c)
                I_IDLE:
                begin
                    next_st.sda_oe = 1'b0;
                end
                I_RX:
                begin
                    if (scl_rise && (st.bit_cnt != BYTE_BITS))
                    begin
                        next_st.shreg = {st.shreg[6:0], st.sda_s[1]};
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && (st.bit_cnt == BYTE_BITS))
                    begin
                        if (st.is_addr)
                        begin
                            if (st.shreg[7:1] == {ADDR_FIXED, st.a0_s[1]})
                            begin
                                next_st.sda_oe = 1'b1;
                                next_st.i2c = I_RACK;
                                next_st.rd = st.shreg[0];
                                next_st.is_addr = 1'b0;
                                next_st.bsel = 1'b0;
                                if (!st.shreg[0])
                                begin
                                    next_st.pen_en = 1'b0;
                                end
                            end
                            else
                            begin
                                // Master code is left unacknowledged
                                if (st.shreg[7:3] == MCODE_TOP)
                                begin
                                    next_st.hs = 1'b1;
                                end
                                next_st.i2c = I_IDLE;
                            end
                        end
                        else
                        begin
                            next_st.sda_oe = 1'b1;
                            next_st.i2c = I_RACK;
                            if (st.shreg[7:4] == FN_SETUP)
                            begin
                                next_st.pull90 = st.shreg[SET_PULL];
                                next_st.filt_byp = st.shreg[SET_BYP];
                            end
                            else
                            begin
                                next_st.cmd = st.shreg;
                                next_st.pend = 1'b1;
                            end
                        end
                    end
                end
                I_RACK:
                begin
                    // Ack held low until SCL falls after the ninth pulse
                    if (scl_fall)
                    begin
                        next_st.sda_oe = 1'b0;
                        next_st.bit_cnt = 4'h0;
                        if (!st.rd)
                        begin
                            next_st.i2c = I_RX;
                        end
                        else if (st.hs && !st.res_ready)
                        begin
                            next_st.scl_oe = 1'b1;
                            next_st.i2c = I_WAIT;
                        end
                        else
                        begin
                            next_st.shreg = rd_byte(1'b0);
                            next_st.sda_oe = ~next_st.shreg[7];
                            next_st.bit_cnt = 4'h1;
                            next_st.i2c = I_TX;
                        end
                    end
                end
                I_WAIT:
                begin
                    // SCL is held low, so SDA may change here
                    if (st.res_ready)
                    begin
                        next_st.shreg = rd_byte(1'b0);
                        next_st.sda_oe = ~next_st.shreg[7];
                        next_st.bit_cnt = 4'h1;
                        next_st.i2c = I_TX;
                    end
                end
                I_TX:
                begin
                    // SCL let go a cycle after the first bit, never with it
                    next_st.scl_oe = 1'b0;
                    if (scl_fall)
                    begin
                        if (st.bit_cnt == BYTE_BITS)
                        begin
                            next_st.sda_oe = 1'b0;
                            next_st.i2c = I_TACK;
                        end
                        else
                        begin
                            next_st.sda_oe = ~st.shreg[6];
                            next_st.shreg = {st.shreg[6:0], 1'b0};
                            next_st.bit_cnt = st.bit_cnt + 4'h1;
                        end
                    end
                end
                I_TACK:
                begin
                    if (scl_rise)
                    begin
                        next_st.mack = ~st.sda_s[1];
                    end
                    else if (scl_fall)
                    begin
                        if (st.mack)
                        begin
                            next_st.bsel = ~st.bsel;
                            next_st.shreg = rd_byte(~st.bsel);
                            next_st.sda_oe = ~next_st.shreg[7];
                            next_st.bit_cnt = 4'h1;
                            next_st.i2c = I_TX;
                        end
                        else
                        begin
                            // Line left high so the master can STOP
                            next_st.sda_oe = 1'b0;
                            next_st.i2c = I_IDLE;
                        end
                    end
                end
                default:
                begin
                    next_st.i2c = I_IDLE;
                    next_st.sda_oe = 1'b0;
                    next_st.scl_oe = 1'b0;
                end
            endcase
        end

        // Command start
        if (launch)
        begin
            next_st.pend = 1'b0;
            next_st.hold = st.cmd[CMD_HOLD];
            next_st.mode8 = st.cmd[CMD_MODE];
            next_st.chan = fn;
            next_st.byp_run = st.filt_byp;
            next_st.pen_en = 1'b0;
            next_st.x_drv = (fn == FN_DRV_X) || (fn == FN_MEAS_X);
            next_st.y_drv = (fn == FN_DRV_Y) || (fn == FN_MEAS_Y);
            next_st.yx_drv = (fn == FN_DRV_YX) || (fn == FN_MEAS_Z1) || (fn == FN_MEAS_Z2);
            if ((fn == FN_DRV_X) || (fn == FN_DRV_Y) || (fn == FN_DRV_YX))
            begin
                // Drivers stay on for settling; nothing is converted
                next_st.drv_only = 1'b1;
                next_st.measuring = 1'b0;
                next_st.conv = C_IDLE;
            end
            else
            begin
                next_st.drv_only = 1'b0;
                next_st.measuring = 1'b1;
                next_st.res_ready = 1'b0;
                next_st.div = 4'h0;
                next_st.step = 5'h00;
                next_st.smp = 3'h0;
                next_st.conv = C_RUN;
            end
        end
        else
        begin
            case (st.conv)
                C_IDLE:
                begin
                    next_st.div = 4'h0;
                end
                C_RUN:
                begin
                    next_st.div = st.div + 4'h1;
                    if (st.div == div_max - 4'h1)
                    begin
                        next_st.div = 4'h0;
                        next_st.adc_step = 1'b1;
                        next_st.step = st.step + 5'h01;
                        if (st.step == steps - 5'h01)
                        begin
                            next_st.step = 5'h00;
                            next_st.adc_sample = 1'b1;
                            next_st.sbuf[st.smp] = adc_code;
                            next_st.smp = st.smp + 3'h1;
                            if (st.smp == nsmp)
                            begin
                                next_st.conv = C_DONE;
                            end
                        end
                    end
                end
                C_DONE:
                begin
                    // Codes pass unchanged: plain unsigned binary
                    next_st.result = st.byp_run ? st.sbuf[0] : mav_avg;
                    next_st.res_ready = 1'b1;
                    next_st.measuring = 1'b0;
                    next_st.conv = C_IDLE;
                    if (!st.hold)
                    begin
                        next_st.x_drv = 1'b0;
                        next_st.y_drv = 1'b0;
                        next_st.yx_drv = 1'b0;
                        next_st.pen_en = 1'b1;
                    end
                end
                default:
                begin
                    next_st.conv = C_IDLE;
                end
            endcase
        end

        // Pen detect path
        next_st.adc_on = next_st.measuring | next_st.hold;
        next_st.pen_connect = next_st.pen_en & ~next_st.measuring & ~next_st.drv_only;
        next_st.y_low_gnd = next_st.pen_connect;
        if (next_st.drv_only)
        begin
            next_st.irq_n = 1'b0;
        end
        else if (next_st.pen_connect)
        begin
            next_st.irq_n = st.pen_s[1];
        end
        else
        begin
            next_st.irq_n = 1'b1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.scl_s <= 3'h7;
            st.sda_s <= 3'h7;
            st.pen_s <= 2'h3;
            st.pen_en <= 1'b1;
            st.pen_connect <= 1'b1;
            st.y_low_gnd <= 1'b1;
            st.irq_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign scl_out = st.sda_o;
    assign scl_oe = st.scl_oe;
    assign sda_out = st.sda_o;
    assign sda_oe = st.sda_oe;
    assign adc_channel = st.chan;
    assign adc_on = st.adc_on;
    assign adc_mode8 = st.mode8;
    assign adc_step = st.adc_step;
    assign adc_sample = st.adc_sample;
    assign x_drv_on = st.x_drv;
    assign y_drv_on = st.y_drv;
    assign yx_drv_on = st.yx_drv;
    assign y_low_gnd = st.y_low_gnd;
    assign pen_connect = st.pen_connect;
    assign pen_touch_irq_n = st.irq_n;
    assign irq_pull_90k = st.pull90;
    assign filter_bypass = st.filt_byp;
    assign result = st.result;
    assign result_valid = st.res_ready;

endmodule // tch_ctrl

`default_nettype wire

// ---- hw/tch_mav.sv ----
`timescale 1ns/10ps
`default_nettype none

module tch_mav
    import tch_pkg::*;
#(
    parameter int W = SMP_W,
    parameter int N = FILT_N
)
(
    // Samples in, filtered value out
    input wire logic [N-1:0][W-1:0] smp,
    output logic [W-1:0] avg
);

    logic [N-1:0][3:0] rank;
    logic [W+1:0] sum;
    logic [W+DIV3_SH+1:0] prod;

    // ****************************************
    // Rank each entry; ties broken by index
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_rank
            always_comb
            begin
                rank[i] = 4'h0;
                for (int j = 0; j < N; j++)
                begin
                    if ((smp[j] < smp[i]) || ((smp[j] == smp[i]) && (j < i)))
                    begin
                        rank[i] = rank[i] + 4'h1;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Mean of the middle three
    // ****************************************
    always_comb
    begin
        sum = '0;
        for (int k = 0; k < N; k++)
        begin
            if ((int'(rank[k]) >= N / 2 - 1) && (int'(rank[k]) <= N / 2 + 1))
            begin
                sum = sum + (W+2)'(smp[k]);
            end
        end
        // Multiply-shift stands in for a divider; exact for this range
        prod = (W+DIV3_SH+2)'(sum * DIV3_MUL);
        avg = prod[DIV3_SH +: W];
    end

endmodule // tch_mav

`default_nettype wire

// ---- hw/tch_pkg.sv ----
package tch_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int ADC_HZ_FAST = 4_000_000;
    localparam int ADC_HZ_SLOW = 2_000_000;
    // Rounded down, so the converter clock never runs slower than asked
    localparam logic [3:0] DIV_FAST = 4'(CLK_HZ / ADC_HZ_FAST);
    localparam logic [3:0] DIV_SLOW = 4'(CLK_HZ / ADC_HZ_SLOW);
    localparam logic [4:0] BITS_WIDE = 5'h0C;
    localparam logic [4:0] BIT_TRIM = 5'h04;
    localparam logic [4:0] OVH_STEPS = 5'h04;

    // ****************************************
    // Filter
    // ****************************************
    localparam int SMP_W = 12;
    localparam int FILT_N = 7;
    localparam logic [2:0] FILT_LAST = 3'h6;
    localparam logic [16:0] DIV3_MUL = 17'h0_AAAB;
    localparam int DIV3_SH = 17;

    // ****************************************
    // Bus and command fields
    // ****************************************
    localparam logic [5:0] ADDR_FIXED = 6'h24;
    localparam logic [4:0] MCODE_TOP = 5'h01;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int CMD_HOLD = 2;
    localparam int CMD_MODE = 1;
    localparam int SET_PULL = 0;
    localparam int SET_BYP = 1;
    localparam logic [3:0] FN_SETUP = 4'hB;
    localparam logic [3:0] FN_DRV_X = 4'h8;
    localparam logic [3:0] FN_DRV_Y = 4'h9;
    localparam logic [3:0] FN_DRV_YX = 4'hA;
    localparam logic [3:0] FN_MEAS_X = 4'hC;
    localparam logic [3:0] FN_MEAS_Y = 4'hD;
    localparam logic [3:0] FN_MEAS_Z1 = 4'hE;
    localparam logic [3:0] FN_MEAS_Z2 = 4'hF;

    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_RX = 3'b001,
        I_RACK = 3'b010,
        I_TX = 3'b011,
        I_TACK = 3'b100,
        I_WAIT = 3'b101
    } tch_i2c_e;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_RUN = 2'b01,
        C_DONE = 2'b10
    } tch_conv_e;

endpackage
